// >>> cre_boost_timer.sv
// Hold timer for the raised loop current limit after a ring burst.
`timescale 1ns/1ns
module cre_boost_timer #(
  parameter int HOLD_CYC = cre_pkg::BOOST_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic enable,
  input  wire logic burst_end,
  output logic      active
);

  typedef struct packed {
    logic [23:0] cnt;
    logic        active;
  } cre_boost_s;

  cre_boost_s s_q;
  cre_boost_s s_d;

  // Clearing the enable drops the boost at once rather than waiting out the hold.
  always_comb begin
    s_d = s_q;
    if (!enable) begin
      s_d = '0;
    end else if (burst_end) begin
      s_d.cnt    = 24'(HOLD_CYC - 1);
      s_d.active = 1'b1;
    end else if (s_q.cnt != 24'h000000) begin
      s_d.cnt = s_q.cnt - 24'h000001;
    end else begin
      s_d.active = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign active = s_q.active;

endmodule : cre_boost_timer

// >>> cre_pkg.sv
// Package with the register map, reset values, field layout and timing of the result bank.
package cre_pkg;

  localparam int          NUM_REGS        = 11;
  localparam logic [7:0]  RING_MM_OFS     = 8'h62;
  localparam logic [7:0]  TIP_MM_OFS      = 8'h63;
  localparam logic [7:0]  DIFF_GAIN_OFS   = 8'h64;
  localparam logic [7:0]  CM_GAIN_OFS     = 8'h65;
  localparam logic [7:0]  CUR_LIM_OFS     = 8'h66;
  localparam logic [7:0]  MON_OFS_OFS     = 8'h67;
  localparam logic [7:0]  SIGNS_OFS       = 8'h68;
  localparam logic [7:0]  DAC_OFS_OFS     = 8'h69;
  localparam logic [7:0]  CM_BAL_OFS      = 8'h6a;
  localparam logic [7:0]  DC_PEAK_OFS     = 8'h6b;
  localparam logic [7:0]  ENH_OFS         = 8'h6c;

  localparam logic [7:0]  RING_MM_RST     = 8'h10;
  localparam logic [7:0]  TIP_MM_RST      = 8'h10;
  localparam logic [7:0]  DIFF_GAIN_RST   = 8'h10;
  localparam logic [7:0]  CM_GAIN_RST     = 8'h11;
  localparam logic [7:0]  CUR_LIM_RST     = 8'h08;
  localparam logic [7:0]  MON_OFS_RST     = 8'h88;
  localparam logic [7:0]  SIGNS_RST       = 8'h00;
  localparam logic [7:0]  DAC_OFS_RST     = 8'h00;
  localparam logic [7:0]  CM_BAL_RST      = 8'h20;
  localparam logic [7:0]  DC_PEAK_RST     = 8'h08;
  localparam logic [7:0]  ENH_RST         = 8'h00;

  localparam logic [7:0]  MASK_5          = 8'h1f;
  localparam logic [7:0]  MASK_4          = 8'h0f;
  localparam logic [7:0]  MASK_6          = 8'h3f;
  localparam logic [7:0]  MASK_8          = 8'hff;
  localparam logic [7:0]  MASK_ENH        = 8'hf7;

  localparam int          MON_A_POS       = 4;
  localparam int          MON_B_POS       = 0;
  localparam int          DAC_POS_BIT     = 3;
  localparam int          DAC_NEG_BIT     = 2;
  localparam int          ADC_POS_BIT     = 1;
  localparam int          ADC_NEG_BIT     = 0;
  localparam int          BOOST_BIT       = 7;
  localparam int          FSK_BIT         = 6;
  localparam int          SPEEDUP_BIT     = 5;
  localparam int          EXT_IMP_BIT     = 4;
  localparam int          LC_VOLT_BIT     = 2;
  localparam int          SQUELCH_BIT     = 1;
  localparam int          HYST_BIT        = 0;

  localparam logic [7:0]  HYST_UPPER_IDX  = 8'h1c;
  localparam logic [7:0]  HYST_LOWER_IDX  = 8'h2b;
  localparam logic [7:0]  FSK_COEF_FIRST  = 8'h63;
  localparam int          BOOST_LIMIT_MA  = 41;

  localparam int          CLK_HZ          = 100_000_000;
  localparam int          TONE_FAST_HZ    = 24_000;
  localparam int          TONE_SLOW_HZ    = 8_000;
  localparam int          BOOST_TIME_US   = 10_000;
  localparam int          TONE_FAST_CYC   = CLK_HZ / TONE_FAST_HZ;
  localparam int          TONE_SLOW_CYC   = CLK_HZ / TONE_SLOW_HZ;
  localparam int          BOOST_CYC       = BOOST_TIME_US * (CLK_HZ / 1_000_000);

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cre_bus_s;

  typedef struct packed {
    logic [NUM_REGS-1:0]      done;
    logic [NUM_REGS-1:0][7:0] value;
  } cre_cal_s;

  typedef struct packed {
    logic current_limit_boost;
    logic tone_tick;
    logic cadence_tick;
    logic fsk_coef_sel;
    logic speedup;
    logic lc_voltage;
    logic lc_hyst;
    logic squelch;
    logic ext_imp;
  } cre_ctl_s;

  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] regs;
    logic [7:0]               rd_data;
    cre_ctl_s                 ctl;
  } cre_top_s;

  function automatic logic [7:0] reg_mask(input logic [3:0] idx);
    unique case (idx)
      4'h0, 4'h1, 4'h2, 4'h3: reg_mask = MASK_5;
      4'h4, 4'h6, 4'h9:       reg_mask = MASK_4;
      4'h8:                   reg_mask = MASK_6;
      4'ha:                   reg_mask = MASK_ENH;
      default:                reg_mask = MASK_8;
    endcase
  endfunction : reg_mask

  function automatic logic [7:0] reg_reset(input logic [3:0] idx);
    unique case (idx)
      4'h0:    reg_reset = RING_MM_RST;
      4'h1:    reg_reset = TIP_MM_RST;
      4'h2:    reg_reset = DIFF_GAIN_RST;
      4'h3:    reg_reset = CM_GAIN_RST;
      4'h4:    reg_reset = CUR_LIM_RST;
      4'h5:    reg_reset = MON_OFS_RST;
      4'h6:    reg_reset = SIGNS_RST;
      4'h7:    reg_reset = DAC_OFS_RST;
      4'h8:    reg_reset = CM_BAL_RST;
      4'h9:    reg_reset = DC_PEAK_RST;
      default: reg_reset = ENH_RST;
    endcase
  endfunction : reg_reset

endpackage : cre_pkg

// >>> cre_regs.sv
// Calibration result and enhancement enable register bank with its control outputs.
//
// Function
// - Ring and tip mismatch, five-bit fields each.
// - Current limit result is a low nibble.
// - Monitor offsets packed upper and lower nibble.
// - Four offset sign bits in bits three..zero.
// - DAC offset result fills all eight bits.
// - Balance result six bits, upper bits zero.
// - Boost bit raises current limit after bursts.
// - Fast tone clock only with enhance and release.
// - Enhanced mode with release selects dedicated FSK coefficient set.
// - Enhanced mode with release, cadence timers use finer step.
// - Enhance clear always uses normal coefficients.
// - Speedup bit selects multi-threshold converter control.
// - Loop closure from voltage or from current.
// - Hysteresis bit enables loop closure hysteresis.
`timescale 1ns/1ns
module cre_regs #(
  parameter int TONE_FAST_CYC = cre_pkg::TONE_FAST_CYC,
  parameter int TONE_SLOW_CYC = cre_pkg::TONE_SLOW_CYC,
  parameter int BOOST_CYC     = cre_pkg::BOOST_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire cre_pkg::cre_bus_s bus,
  input  wire cre_pkg::cre_cal_s cal,
  input  wire logic             release_bit,
  input  wire logic             ring_burst_end,
  output logic [7:0]            rd_data,
  output cre_pkg::cre_ctl_s     ctl,
  output logic [7:0]            enh_bits
);

  ////////////////////////////////////////////////////////////////////////////////
  // State and helpers.

  cre_pkg::cre_top_s s_q;
  cre_pkg::cre_top_s s_d;
  logic              tone_tick;
  logic              boost_active;
  logic              fast_mode;
  logic [7:0]        enh;

  function automatic logic in_map(input logic [7:0] addr);
    in_map = (addr >= cre_pkg::RING_MM_OFS) && (addr <= cre_pkg::ENH_OFS);
  endfunction : in_map

  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - cre_pkg::RING_MM_OFS;
    reg_index = diff[3:0];
  endfunction : reg_index

  assign enh = s_q.regs[cre_pkg::NUM_REGS-1];

  assign fast_mode = enh[cre_pkg::FSK_BIT] & release_bit;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing helpers.

  cre_tone_clk #(
    .FAST_CYC (TONE_FAST_CYC),
    .SLOW_CYC (TONE_SLOW_CYC)
  ) u_tone (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .fast (fast_mode),
    .tick (tone_tick)
  );

  cre_boost_timer #(
    .HOLD_CYC (BOOST_CYC)
  ) u_boost (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .enable    (enh[cre_pkg::BOOST_BIT]),
    .burst_end (ring_burst_end),
    .active    (boost_active)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    s_d = s_q;
    if (bus.wr && in_map(bus.addr)) begin
      s_d.regs[reg_index(bus.addr)] = bus.wdata & cre_pkg::reg_mask(reg_index(bus.addr));
    end
    for (int i = 0; i < cre_pkg::NUM_REGS - 1; i++) begin
      if (cal.done[i]) begin
        s_d.regs[i] = cal.value[i] & cre_pkg::reg_mask(4'(i));
      end
    end
    // Unmapped reads answer zero so a stray address never shows stale data.
    if (bus.rd) begin
      s_d.rd_data = in_map(bus.addr) ? s_q.regs[reg_index(bus.addr)] : 8'h00;
    end
    s_d.ctl.current_limit_boost = boost_active;
    s_d.ctl.tone_tick    = tone_tick;
    s_d.ctl.cadence_tick = tone_tick;
    s_d.ctl.fsk_coef_sel = fast_mode;
    s_d.ctl.speedup      = enh[cre_pkg::SPEEDUP_BIT];
    s_d.ctl.lc_voltage   = enh[cre_pkg::LC_VOLT_BIT];
    s_d.ctl.lc_hyst      = enh[cre_pkg::HYST_BIT];
    s_d.ctl.squelch      = enh[cre_pkg::SQUELCH_BIT];
    s_d.ctl.ext_imp      = enh[cre_pkg::EXT_IMP_BIT];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < cre_pkg::NUM_REGS; i++) begin
        s_q.regs[i] <= cre_pkg::reg_reset(4'(i));
      end
      s_q.rd_data <= 8'h00;
      s_q.ctl     <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign rd_data  = s_q.rd_data;
  assign ctl      = s_q.ctl;
  assign enh_bits = enh;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence boost_off_s;
    (ce && !enh[cre_pkg::BOOST_BIT]) [*2];
  endsequence

  sequence mon_write_s;
    ce && bus.wr && bus.addr == cre_pkg::MON_OFS_OFS && !cal.done[5];
  endsequence

  sequence burst_armed_s;
    ce && enh[cre_pkg::BOOST_BIT] && ring_burst_end ##1 ce;
  endsequence

  sequence cal_wr_clash_s;
    ce && cal.done[0] && bus.wr && bus.addr == cre_pkg::RING_MM_OFS;
  endsequence

  sequence wr_taken_s;
    ce && bus.wr && in_map(bus.addr) && !cal.done[reg_index(bus.addr)];
  endsequence

  sequence rd_taken_s;
    ce && bus.rd && in_map(bus.addr);
  endsequence

  ring_field_a: assert property (s_q.regs[0][7:5] == 3'h0)
    else $error("ring mismatch reserved bits set");

  tip_field_a: assert property (s_q.regs[1][7:5] == 3'h0)
    else $error("tip mismatch reserved bits set");

  cur_lim_field_a: assert property (s_q.regs[4][7:4] == 4'h0)
    else $error("current limit reserved bits set");

  mon_write_a: assert property (mon_write_s |=> s_q.regs[5] == $past(bus.wdata))
    else $error("monitor offset write lost");

  sign_field_a: assert property (s_q.regs[6][7:4] == 4'h0)
    else $error("offset sign reserved bits set");

  dac_cal_a: assert property (ce && cal.done[7] |=> s_q.regs[7] == $past(cal.value[7]))
    else $error("dac offset result not loaded");

  bal_field_a: assert property (s_q.regs[8][7:6] == 2'h0)
    else $error("balance reserved bits set");

  boost_off_a: assert property (boost_off_s |=> !ctl.current_limit_boost)
    else $error("boost active with enable clear");

  boost_on_a: assert property (burst_armed_s |=> ctl.current_limit_boost)
    else $error("boost missing after burst end");

  fsk_sel_a: assert property (ce |=> ctl.fsk_coef_sel == $past(fast_mode))
    else $error("coefficient bank select wrong");

  normal_sel_a: assert property (ce && !enh[cre_pkg::FSK_BIT] |=> !ctl.fsk_coef_sel)
    else $error("fsk bank used with enhance clear");

  speedup_out_a: assert property (ce |=> ctl.speedup == $past(enh[cre_pkg::SPEEDUP_BIT]))
    else $error("speedup output mismatch");

  lc_src_a: assert property (ce |=> ctl.lc_voltage == $past(enh[cre_pkg::LC_VOLT_BIT]))
    else $error("loop closure source mismatch");

  hyst_out_a: assert property (ce |=> ctl.lc_hyst == $past(enh[cre_pkg::HYST_BIT]))
    else $error("hysteresis output mismatch");

  cal_wins_a: assert property (cal_wr_clash_s |=>
    s_q.regs[0] == ($past(cal.value[0]) & cre_pkg::MASK_5))
    else $error("calibration lost to write");

  hold_val_a: assert property (!ce |=> $stable(s_q.regs))
    else $error("registers moved while frozen");

  unmapped_rd_a: assert property (ce && bus.rd && !in_map(bus.addr) |=> rd_data == 8'h00)
    else $error("unmapped read not zero");

  // The first edge after any release of reset must see the reset image, not leftovers.
  reset_vals_a: assert property ($fell(rst) |-> s_q.regs[0] == cre_pkg::RING_MM_RST
    && s_q.regs[1] == cre_pkg::TIP_MM_RST && s_q.regs[4] == cre_pkg::CUR_LIM_RST
    && s_q.regs[5] == cre_pkg::MON_OFS_RST && s_q.regs[9] == cre_pkg::DC_PEAK_RST
    && s_q.regs[10] == cre_pkg::ENH_RST && rd_data == 8'h00 && ctl == '0)
    else $error("reset values wrong");

  diff_field_a: assert property (s_q.regs[2][7:5] == 3'h0)
    else $error("differential gain reserved bits set");

  cm_gain_field_a: assert property (s_q.regs[3][7:5] == 3'h0)
    else $error("common mode gain reserved bits set");

  peak_field_a: assert property (s_q.regs[9][7:4] == 4'h0)
    else $error("peak monitor reserved bits set");

  enh_rsvd_a: assert property (s_q.regs[10][3] == 1'b0)
    else $error("enhancement reserved bit set");

  wr_lands_a: assert property (wr_taken_s |=>
    s_q.regs[$past(reg_index(bus.addr))]
      == $past(bus.wdata & cre_pkg::reg_mask(reg_index(bus.addr))))
    else $error("register write lost");

  rd_answer_a: assert property (rd_taken_s |=> rd_data == $past(s_q.regs[reg_index(bus.addr)]))
    else $error("read data wrong");

  rd_hold_a: assert property (!(ce && bus.rd) |=> $stable(rd_data))
    else $error("read data moved without a read");

  unmapped_wr_a: assert property (ce && bus.wr && !in_map(bus.addr) && cal.done == '0
    |=> $stable(s_q.regs))
    else $error("unmapped write changed a register");

  ring_cal_a: assert property (ce && cal.done[0] |=>
    s_q.regs[0] == ($past(cal.value[0]) & cre_pkg::MASK_5))
    else $error("ring mismatch result not loaded");

  tip_cal_a: assert property (ce && cal.done[1] |=>
    s_q.regs[1] == ($past(cal.value[1]) & cre_pkg::MASK_5))
    else $error("tip mismatch result not loaded");

  cur_lim_cal_a: assert property (ce && cal.done[4] |=>
    s_q.regs[4] == ($past(cal.value[4]) & cre_pkg::MASK_4))
    else $error("current limit result not loaded");

  mon_cal_a: assert property (ce && cal.done[5] |=>
    s_q.regs[5] == $past(cal.value[5]))
    else $error("monitor offset result not loaded");

  sign_cal_a: assert property (ce && cal.done[6] |=>
    s_q.regs[6] == ($past(cal.value[6]) & cre_pkg::MASK_4))
    else $error("offset signs not loaded");

  bal_cal_a: assert property (ce && cal.done[8] |=>
    s_q.regs[8] == ($past(cal.value[8]) & cre_pkg::MASK_6))
    else $error("balance result not loaded");

  enh_no_cal_a: assert property (ce && cal.done[10] && !bus.wr |=> $stable(s_q.regs[10]))
    else $error("enhancement register loaded by calibration");

  squelch_out_a: assert property (ce |=> ctl.squelch == $past(enh[cre_pkg::SQUELCH_BIT]))
    else $error("squelch output mismatch");

  ext_imp_out_a: assert property (ce |=> ctl.ext_imp == $past(enh[cre_pkg::EXT_IMP_BIT]))
    else $error("reference resistor output mismatch");

  cadence_a: assert property (ctl.cadence_tick == ctl.tone_tick)
    else $error("cadence tick off the tone tick");

  fsk_rel_a: assert property (ce && !release_bit |=> !ctl.fsk_coef_sel)
    else $error("fsk bank used without release");

  fsk_on_a: assert property (ce && enh[cre_pkg::FSK_BIT] && release_bit
    |=> ctl.fsk_coef_sel)
    else $error("fsk bank not used when enhanced");

  frozen_out_a: assert property (!ce |=> $stable(ctl) && $stable(rd_data))
    else $error("outputs moved while frozen");

endmodule : cre_regs

// >>> cre_tone_clk.sv
// Tick generator that paces tone generator one and its cadence timers.
`timescale 1ns/1ns
module cre_tone_clk #(
  parameter int FAST_CYC = cre_pkg::TONE_FAST_CYC,
  parameter int SLOW_CYC = cre_pkg::TONE_SLOW_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic fast,
  output logic      tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } cre_tone_s;

  cre_tone_s s_q;
  cre_tone_s s_d;
  logic [15:0] last;

  // A rate change takes effect at once against the running count, so a switch to fast can emit a short period.
  always_comb begin
    last = fast ? 16'(FAST_CYC - 1) : 16'(SLOW_CYC - 1);
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt >= last) begin
      s_d.cnt  = 16'h0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : cre_tone_clk

// >>> tb_cre_regs.sv
// Self-checking bench for the calibration result and enhancement register bank.
`timescale 1ns/1ns
module tb_cre_regs;
  localparam int FAST = 6;
  localparam int SLOW = 18;
  localparam int HOLD = 20;
  logic              clk;
  logic              rst;
  logic              ce;
  cre_pkg::cre_bus_s bus;
  cre_pkg::cre_cal_s cal;
  logic              release_bit;
  logic              ring_burst_end;
  logic [7:0]        rd_data;
  cre_pkg::cre_ctl_s ctl;
  logic [7:0]        enh_bits;
  int                err_total;
  int                checked;
  int                cyc = 0;
  int                n;
  logic [7:0]        rv;
  logic [7:0]        rst_v [11] = '{8'h10, 8'h10, 8'h10, 8'h11, 8'h08, 8'h88, 8'h00, 8'h00,
                                    8'h20, 8'h08, 8'h00};
  logic [7:0]        msk   [11] = '{8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h0f, 8'hff, 8'h0f, 8'hff,
                                    8'h3f, 8'h0f, 8'hf7};
  logic [7:0]        ctl_w [6]  = '{8'h20, 8'h04, 8'h01, 8'h02, 8'h10, 8'hff};

`define CHK(got, exp) begin \
    checked++; \
    if ((got) !== (exp)) begin \
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
      err_total++; \
    end \
  end

  cre_regs #(
    .TONE_FAST_CYC (FAST),
    .TONE_SLOW_CYC (SLOW),
    .BOOST_CYC     (HOLD)
  ) cre_regs_inst (
    .clk            (clk),
    .rst            (rst),
    .ce             (ce),
    .bus            (bus),
    .cal            (cal),
    .release_bit    (release_bit),
    .ring_burst_end (ring_burst_end),
    .rd_data        (rd_data),
    .ctl            (ctl),
    .enh_bits       (enh_bits)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // A hang ends the run here; the ceiling is well above the sum of all scenarios.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      stop_test();
    end
  end

////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks=%0d errors=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    bus.wr = 1'b1;
    bus.addr = a;
    bus.wdata = d;
    @(negedge clk);
    bus.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    bus.rd = 1'b1;
    bus.addr = a;
    @(negedge clk);
    bus.rd = 1'b0;
    @(negedge clk);
    d = rd_data;
  endtask : rd

  // Counts cycles to the next tone tick; the cadence tick must track it every cycle.
  task automatic gap(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
      `CHK(ctl.cadence_tick, ctl.tone_tick)
    end while (ctl.tone_tick !== 1'b1 && c < 100);
  endtask : gap

////////////////////////////////////////////////////////////////////////////////
  task automatic t_fields();
    for (int i = 0; i < 11; i++) begin
      rd(8'h62 + 8'(i), rv);
      `CHK(rv, rst_v[i])
      wr(8'h62 + 8'(i), 8'hff);
      rd(8'h62 + 8'(i), rv);
      `CHK(rv, msk[i])
      wr(8'h62 + 8'(i), 8'h00);
      rd(8'h62 + 8'(i), rv);
      `CHK(rv, 8'h00)
    end
    wr(8'h67, 8'ha5);
    rd(8'h67, rv);
    `CHK(rv, 8'ha5)
    wr(8'h6d, 8'hff);
    rd(8'h6d, rv);
    `CHK(rv, 8'h00)
    ce = 1'b0;
    wr(8'h69, 8'h55);
    ce = 1'b1;
    rd(8'h69, rv);
    `CHK(rv, 8'h00)
  endtask : t_fields

  task automatic t_cal();
    for (int i = 0; i < 11; i++) begin
      @(negedge clk);
      cal.done[i] = 1'b1;
      cal.value[i] = 8'hff;
      @(negedge clk);
      cal.done = '0;
      rd(8'h62 + 8'(i), rv);
      `CHK(rv, (i == 10) ? 8'h00 : msk[i])
    end
    // Calibration and a software write landing together: calibration wins.
    @(negedge clk);
    cal.done[7] = 1'b1;
    cal.value[7] = 8'h3c;
    bus.wr = 1'b1;
    bus.addr = 8'h69;
    bus.wdata = 8'h11;
    @(negedge clk);
    cal.done = '0;
    bus.wr = 1'b0;
    rd(8'h69, rv);
    `CHK(rv, 8'h3c)
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    `CHK(rd_data, 8'h00)
    `CHK(ctl, 9'h000)
    rd(8'h62, rv);
    `CHK(rv, 8'h10)
    rd(8'h69, rv);
    `CHK(rv, 8'h00)
  endtask : t_cal

  task automatic t_ctl();
    for (int i = 0; i < 6; i++) begin
      wr(8'h6c, ctl_w[i]);
      repeat (2) @(negedge clk);
      `CHK(ctl.speedup, ctl_w[i][5])
      `CHK(ctl.ext_imp, ctl_w[i][4])
      `CHK(ctl.lc_voltage, ctl_w[i][2])
      `CHK(ctl.squelch, ctl_w[i][1])
      `CHK(ctl.lc_hyst, ctl_w[i][0])
      `CHK(enh_bits, ctl_w[i] & 8'hf7)
    end
    for (int m = 0; m < 4; m++) begin
      wr(8'h6c, m[1] ? 8'h40 : 8'h00);
      release_bit = m[0];
      repeat (2) @(negedge clk);
      `CHK(ctl.fsk_coef_sel, m[1] & m[0])
      gap(n);
      gap(n);
      gap(n);
      `CHK(n, (m == 3) ? FAST : SLOW)
    end
    release_bit = 1'b0;
  endtask : t_ctl

  task automatic t_boost();
    wr(8'h6c, 8'h00);
    for (int k = 0; k < 3; k++) begin
      if (k == 1)
        wr(8'h6c, 8'h80);
      @(negedge clk);
      ring_burst_end = 1'b1;
      @(negedge clk);
      ring_burst_end = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(ctl.current_limit_boost, k != 0)
      if (k == 1) begin
        repeat (14) @(negedge clk);
        `CHK(ctl.current_limit_boost, 1'b1)
        repeat (10) @(negedge clk);
        `CHK(ctl.current_limit_boost, 1'b0)
      end
    end
    wr(8'h6c, 8'h00);
    repeat (3) @(negedge clk);
    `CHK(ctl.current_limit_boost, 1'b0)
  endtask : t_boost

////////////////////////////////////////////////////////////////////////////////
  initial begin
    err_total = 0;
    checked = 0;
    rst = 1'b1;
    ce = 1'b1;
    bus = '0;
    cal = '0;
    release_bit = 1'b0;
    ring_burst_end = 1'b0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    `CHK(rd_data, 8'h00)
    `CHK(ctl, 9'h000)
    t_fields();
    t_cal();
    t_ctl();
    t_boost();
    stop_test();
  end
endmodule : tb_cre_regs
